// ---- logic/flash_pd_defs.svh ----
// Constants for the power-down, reset and lock-query command block
`ifndef FLASH_PD_DEFS_SVH
`define FLASH_PD_DEFS_SVH
// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define OP_LOCK_QUERY_A 8'h3c
`define OP_LOCK_QUERY_B 8'h3d
`define OP_POWER_DOWN 8'hb9
`define OP_DEEP_DOWN 8'h79
`define OP_RESUME 8'hab
`define OP_RESET_ENABLE 8'h66
`define OP_RESET_DEVICE 8'h99
`define OP_TERMINATE 8'hf0
`define OP_PROG_PAGE 8'h02
`define OP_PROG_SEQ_A 8'haf
`define OP_PROG_SEQ_B 8'had
`define OP_PROG_DUAL 8'ha2
`define OP_PROG_QUAD 8'h32
`define OP_PROG_RMW 8'h0a
`define OP_PROG_NOERASE 8'h88
`define OP_PROG_SECURITY 8'h9b
`define OP_ERASE_PAGE_A 8'h81
`define OP_ERASE_PAGE_B 8'hdb
`define OP_ERASE_4K 8'h20
`define OP_ERASE_32K 8'h52
`define OP_ERASE_64K 8'hd8
`define OP_ERASE_CHIP_A 8'h60
`define OP_ERASE_CHIP_B 8'hc7
// ------------------------------------------------------------
// Fields and sizes
// ------------------------------------------------------------
`define SLEEP_DEPTH_BIT 7
`define RESET_PIN_EN_BIT 7
`define LOCK_BITS 94
`define LOCK_LOCKED 8'h01
`define LOCK_UNLOCKED 8'h00
// ------------------------------------------------------------
// Timing (ns) and derived cycle counts at 25 MHz
// ------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define SHALLOW_WAKE_NS 3000
`define DEEP_WAKE_NS 100000
`define SHALLOW_WAKE_CYC ((`SHALLOW_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEEP_WAKE_CYC ((`DEEP_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- logic/flash_pd_pkg.sv ----
// Types for the power-down, reset and lock-query command block
package flash_pd_pkg;
    // Power state, Gray coded along idle -> shallow -> deep -> wake -> reset
    typedef enum logic [2:0] {
        PWR_IDLE = 3'h0,
        PWR_SHALLOW = 3'h1,
        PWR_DEEP = 3'h3,
        PWR_WAKE = 3'h2,
        PWR_RESET = 3'h6
    } pwr_state_t;
    // Operation class of an opcode
    typedef enum logic [1:0] {
        CLASS_NONE = 2'h0,
        CLASS_PROGRAM = 2'h1,
        CLASS_ERASE = 2'h3
    } op_class_t;
endpackage

// ---- logic/flash_pd_ctrl.sv ----
// Power-down, reset and lock-query command control of a serial flash
//
// Functional notes
// - Lock query opcodes 3c and 3d identical
// - Return 8-bit lock field, MSB first
// - Field LSB one means block locked
// - Depth select is bit 7, fourth status
// - Depth one: shallow sleep, buffer kept
// - Depth zero: deepest sleep, buffer lost
// - Legacy opcode always enters deepest sleep
// - Resume from shallow: idle, no reset
// - Resume from deepest: internal reset, idle
// - Chip select release never ends shallow
// - Device resets wake either depth, buffer lost
// - Reset pin wakes only if enabled before
// - Software reset pair wakes shallow, keeps buffer
// - Software reset pair ignored in deepest
// - Terminate never wakes from sleep
// - Wait recovery time before normal commands
// - Classify program opcodes for reset handling
// - Classify erase opcodes for reset handling
// - Reset during program/erase: abort, full reset
// - Terminate during program/erase: abort only
// - Ninety-four lock bits back every query
`timescale 1ns/1ns
`include "flash_pd_defs.svh"
module flash_pd_ctrl #(
    parameter int DEEP_WAKE_CYCLES = `DEEP_WAKE_CYC // Long recovery, shortenable
) (
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic sys_rst, // Asynchronous reset, active high (power-on)
    input wire logic spi_sck, // Link clock from host
    input wire logic spi_cs_n, // Chip select, active low
    input wire logic spi_si, // Serial data in
    output logic spi_so, // Serial data out
    output logic spi_so_oe_n, // Output enable, low while driving
    input wire logic jedec_reset, // Pin reset sequence detected, pulse/level
    input wire logic hw_reset_n, // Hardware reset pin, active low
    input wire logic [7:0] fourth_status_reg, // Fourth status register
    input wire logic [7:0] third_status_reg, // Third status register
    input wire logic [`LOCK_BITS-1:0] lock_bits, // Block lock bits
    input wire logic op_busy, // Program/erase in progress
    output logic op_abort, // Abort running operation
    output logic dev_reset, // Full internal reset pulse
    output logic buffer_lost, // Buffer contents undefined, sticky
    output logic cmd_ready, // Normal commands accepted
    output logic sleep_shallow, // In shallow sleep
    output logic sleep_deep, // In deepest sleep
    output logic [1:0] op_class // Class of last operation opcode
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Operation class decode, reported on op_class
    function automatic flash_pd_pkg::op_class_t classify(input logic [7:0] op);
        case (op)
            `OP_PROG_PAGE, `OP_PROG_SEQ_A, `OP_PROG_SEQ_B, `OP_PROG_DUAL,
            `OP_PROG_QUAD, `OP_PROG_RMW, `OP_PROG_NOERASE, `OP_PROG_SECURITY:
                classify = flash_pd_pkg::CLASS_PROGRAM;
            `OP_ERASE_PAGE_A, `OP_ERASE_PAGE_B, `OP_ERASE_4K, `OP_ERASE_32K,
            `OP_ERASE_64K, `OP_ERASE_CHIP_A, `OP_ERASE_CHIP_B:
                classify = flash_pd_pkg::CLASS_ERASE;
            default:
                classify = flash_pd_pkg::CLASS_NONE;
        endcase
    endfunction

    // Map a 24-bit address onto one of the 94 lock bits
    function automatic logic [6:0] lock_index(input logic [23:0] addr);
        if (addr[21:16] == 6'h00) begin
            lock_index = {3'h0, addr[15:12]};
        end else if (addr[21:16] == 6'h3f) begin
            lock_index = 7'(7'd78 + {3'h0, addr[15:12]});
        end else begin
            lock_index = 7'(7'd15 + {1'b0, addr[21:16]});
        end
    endfunction

    // ------------------------------------------------------------
    // Link domain: shift in opcode/address, shift out lock field
    // ------------------------------------------------------------
    logic [5:0] bit_cnt; // Bits received this frame
    logic [31:0] shift_in; // Opcode and address
    logic [7:0] lk_field; // Lock field being shifted out
    logic lk_active; // Lock reply phase
    logic op_tgl; // Toggles when an opcode completes
    logic [7:0] op_byte; // Held opcode, stable across toggle
    logic lq_tgl; // Toggles when a lock query's address is complete, whether or not a reply follows
    logic so_q; // Output bit
    logic so_oe_n; // Output enable, low while driving
    logic [1:0] rdy_sck; // Ready level carried into the link clock
    logic frame_rst; // Ends frame state when chip select is high
    logic [31:0] shift_nx; // Next shift value
    assign frame_rst = spi_cs_n | sys_rst;
    assign shift_nx = {shift_in[30:0], spi_si};

    // Frame receive, reset by the frame's own chip select
    always_ff @(posedge spi_sck or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt <= 6'h00;
            shift_in <= 32'h0;
            lk_active <= 1'b0;
        end else begin
            shift_in <= shift_nx;
            if (bit_cnt != 6'h3f) begin
                bit_cnt <= 6'(bit_cnt + 6'h01);
            end
            if (bit_cnt == 6'd31 && rdy_sck[1] && (shift_nx[31:24] == `OP_LOCK_QUERY_A ||
                                     shift_nx[31:24] == `OP_LOCK_QUERY_B)) begin
                lk_active <= 1'b1;
            end
        end
    end

    // Opcode hand-over toggle; only reset by system reset
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            op_tgl <= 1'b0;
            op_byte <= 8'h00;
            lq_tgl <= 1'b0;
            lk_field <= 8'h00;
        end else if (!spi_cs_n) begin
            if (bit_cnt == 6'd7) begin
                op_byte <= shift_nx[7:0];
                op_tgl <= ~op_tgl;
            end
            if (bit_cnt == 6'd31 && lk_active == 1'b0) begin
                // Query pulls the field for the addressed block
                lk_field <= lock_bits[lock_index(shift_nx[23:0])] ? `LOCK_LOCKED : `LOCK_UNLOCKED;
                if (shift_nx[31:24] == `OP_LOCK_QUERY_A || shift_nx[31:24] == `OP_LOCK_QUERY_B) begin
                    lq_tgl <= ~lq_tgl;
                end
            end else if (lk_active) begin
                lk_field <= {lk_field[6:0], 1'b0};
            end
        end
    end

    // Output changes on falling edge, MSB first
    always_ff @(negedge spi_sck or posedge frame_rst) begin
        if (frame_rst) begin
            so_q <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so_q <= lk_active ? lk_field[7] : 1'b0;
            so_oe_n <= ~lk_active;
        end
    end

    // ------------------------------------------------------------
    // System domain state
    // ------------------------------------------------------------
    typedef struct packed {
        flash_pd_pkg::pwr_state_t pwr; // Power state
        logic [2:0] op_sync; // Opcode toggle synchroniser
        logic op_seen; // Last toggle value taken
        logic [2:0] rstp_sync; // Reset pin synchroniser
        logic [2:0] jed_sync; // Pin reset sequence synchroniser
        logic shallow; // Shallow sleep output
        logic deep; // Deepest sleep output
        logic reset_armed; // Software reset enable seen
        logic pin_en_latched; // Reset pin enable at sleep entry
        logic [16:0] wake_cnt; // Recovery counter
        logic abort; // Abort pulse
        logic rst_pulse; // Reset pulse
        logic lost; // Buffer lost flag
        logic ready; // Normal commands allowed
        logic [1:0] cls; // Last operation class
    } st_t;
    st_t st;
    st_t next_st;
    logic op_new; // New opcode arrived
    logic rst_pin; // Qualified reset pin level
    logic jed; // Qualified pin reset sequence
    assign op_new = (st.op_sync[2] == st.op_sync[1]) && (st.op_sync[1] != st.op_seen);
    assign rst_pin = (st.rstp_sync[2] == st.rstp_sync[1]) && !st.rstp_sync[1];
    assign jed = (st.jed_sync[2] == st.jed_sync[1]) && st.jed_sync[1];

    // Next-state logic for power, reset and abort
    always_comb begin
        next_st = st;
        next_st.op_sync = {st.op_sync[1:0], op_tgl};
        next_st.rstp_sync = {st.rstp_sync[1:0], hw_reset_n};
        next_st.jed_sync = {st.jed_sync[1:0], jedec_reset};
        next_st.abort = 1'b0;
        next_st.rst_pulse = 1'b0;
        if (op_new) begin
            next_st.op_seen = st.op_sync[1];
        end
        case (st.pwr)
            flash_pd_pkg::PWR_IDLE: begin
                // Pin resets and the enable-pair abort and reset
                if (jed || (rst_pin && third_status_reg[`RESET_PIN_EN_BIT])) begin
                    next_st.abort = op_busy;
                    next_st.pwr = flash_pd_pkg::PWR_RESET;
                end else if (op_new) begin
                    next_st.reset_armed = (op_byte == `OP_RESET_ENABLE);
                    if (classify(op_byte) != flash_pd_pkg::CLASS_NONE) begin
                        next_st.cls = classify(op_byte);
                    end
                    if (op_byte == `OP_RESET_DEVICE && st.reset_armed) begin
                        next_st.abort = op_busy;
                        next_st.pwr = flash_pd_pkg::PWR_RESET;
                    end else if (op_byte == `OP_TERMINATE) begin
                        next_st.abort = op_busy;
                    end else if (op_byte == `OP_DEEP_DOWN) begin
                        next_st.pwr = flash_pd_pkg::PWR_DEEP;
                        next_st.lost = 1'b1;
                    end else if (op_byte == `OP_POWER_DOWN) begin
                        next_st.pin_en_latched = third_status_reg[`RESET_PIN_EN_BIT];
                        if (fourth_status_reg[`SLEEP_DEPTH_BIT]) begin
                            next_st.pwr = flash_pd_pkg::PWR_SHALLOW;
                        end else begin
                            next_st.pwr = flash_pd_pkg::PWR_DEEP;
                            next_st.lost = 1'b1;
                        end
                    end
                    if (op_byte == `OP_DEEP_DOWN) begin
                        next_st.pin_en_latched = third_status_reg[`RESET_PIN_EN_BIT];
                    end
                    if (op_byte == `OP_DEEP_DOWN || op_byte == `OP_POWER_DOWN) begin
                        next_st.ready = 1'b0;
                    end
                end
            end
            flash_pd_pkg::PWR_SHALLOW: begin
                // Chip select alone never wakes here
                if (jed || (rst_pin && st.pin_en_latched)) begin
                    next_st.pwr = flash_pd_pkg::PWR_RESET;
                end else if (op_new) begin
                    next_st.reset_armed = (op_byte == `OP_RESET_ENABLE);
                    if (op_byte == `OP_RESUME ||
                        (op_byte == `OP_RESET_DEVICE && st.reset_armed)) begin
                        next_st.pwr = flash_pd_pkg::PWR_WAKE;
                        next_st.wake_cnt = 17'(`SHALLOW_WAKE_CYC);
                    end
                    // Terminate and all others fall through unused
                end
            end
            flash_pd_pkg::PWR_DEEP: begin
                if (jed || (rst_pin && st.pin_en_latched)) begin
                    next_st.pwr = flash_pd_pkg::PWR_RESET;
                end else if (op_new && op_byte == `OP_RESUME) begin
                    next_st.pwr = flash_pd_pkg::PWR_RESET;
                end
                // Reset pair and terminate have no effect here
            end
            flash_pd_pkg::PWR_RESET: begin
                next_st.rst_pulse = 1'b1;
                next_st.lost = 1'b1;
                next_st.reset_armed = 1'b0;
                next_st.cls = 2'h0;
                next_st.ready = 1'b0;
                next_st.pwr = flash_pd_pkg::PWR_WAKE;
                next_st.wake_cnt = 17'(DEEP_WAKE_CYCLES);
            end
            flash_pd_pkg::PWR_WAKE: begin
                if (st.wake_cnt <= 17'h00001) begin
                    next_st.pwr = flash_pd_pkg::PWR_IDLE;
                    next_st.ready = 1'b1;
                end else begin
                    next_st.wake_cnt = 17'(st.wake_cnt - 17'h00001);
                end
            end
            default: begin
                next_st.pwr = flash_pd_pkg::PWR_RESET;
            end
        endcase
        // Sleep levels kept in flops so the outputs never glitch on a state change
        next_st.shallow = (next_st.pwr == flash_pd_pkg::PWR_SHALLOW);
        next_st.deep = (next_st.pwr == flash_pd_pkg::PWR_DEEP);
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{pwr: flash_pd_pkg::PWR_IDLE, op_sync: 3'h0, op_seen: 1'b0, rstp_sync: 3'h7,
                    jed_sync: 3'h0, shallow: 1'b0, deep: 1'b0, reset_armed: 1'b0,
                    pin_en_latched: 1'b0, wake_cnt: 17'h00000, abort: 1'b0, rst_pulse: 1'b0,
                    lost: 1'b1, ready: 1'b1, cls: 2'h0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Ready carried into the link clock; two link edges settle it long before a reply starts
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            rdy_sck <= 2'h0;
        end else begin
            rdy_sck <= {rdy_sck[0], st.ready};
        end
    end

    // Serial output stays in the link domain so bit timing holds
    assign spi_so = so_q;
    assign spi_so_oe_n = so_oe_n;
    assign op_abort = st.abort;
    assign dev_reset = st.rst_pulse;
    assign buffer_lost = st.lost;
    assign cmd_ready = st.ready;
    assign sleep_shallow = st.shallow;
    assign sleep_deep = st.deep;
    assign op_class = st.cls;
endmodule

// ---- verification/flash_pd_ctrl_sva.sv ----
// Assertion checker for the flash power-down and lock-query block
`timescale 1ns/1ns
module flash_pd_ctrl_sva #(
    parameter int DEEP_WAKE_CYCLES = 20 // Long recovery as built
) (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Reset, active high
    input wire logic spi_cs_n, // Chip select
    input wire logic spi_so, // Serial out
    input wire logic spi_so_oe_n, // Output enable, low drives
    input wire logic op_busy, // Operation running
    input wire logic op_abort, // Abort pulse
    input wire logic dev_reset, // Reset pulse
    input wire logic cmd_ready, // Commands accepted
    input wire logic sleep_shallow, // Shallow sleep
    input wire logic sleep_deep // Deepest sleep
);
    // ----------------------------------------
    // Clocking
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_ready_sleep: assert property ((sleep_shallow || sleep_deep) |-> !cmd_ready)
        else $error("ready while asleep");
    chk_one_depth: assert property (!(sleep_shallow && sleep_deep))
        else $error("both sleep depths at once");
    chk_deep_recover: assert property ($fell(sleep_deep) |-> !cmd_ready [*8])
        else $error("deep wake recovered too soon");
    chk_shallow_recover: assert property ($fell(sleep_shallow) |-> !cmd_ready [*2])
        else $error("shallow wake recovered too soon");
    chk_reset_pulse: assert property (dev_reset |=> !dev_reset)
        else $error("reset pulse too long");
    chk_abort_pulse: assert property (op_abort |=> !op_abort)
        else $error("abort pulse too long");
    chk_abort_cause: assert property (op_abort |-> op_busy || $past(op_busy))
        else $error("abort without running operation");
    chk_reply_release: assert property (spi_cs_n [*3] |-> spi_so_oe_n)
        else $error("reply driven while deselected");
    chk_sleep_silent: assert property ((sleep_shallow || sleep_deep) |-> spi_so_oe_n)
        else $error("reply driven while asleep");
    // Main scenarios reached
    cover property ($fell(spi_so_oe_n));
    cover property ($rose(sleep_shallow));
    cover property ($rose(sleep_deep));
    cover property (dev_reset && op_busy);
endmodule
bind flash_pd_ctrl flash_pd_ctrl_sva #(.DEEP_WAKE_CYCLES(DEEP_WAKE_CYCLES)) u_sva (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .op_busy(op_busy),
    .op_abort(op_abort), .dev_reset(dev_reset), .cmd_ready(cmd_ready), .sleep_shallow(sleep_shallow),
    .sleep_deep(sleep_deep));

// ---- verification/flash_host_model.sv ----
// Host serial controller model issuing flash opcodes
`timescale 1ns/1ns
module flash_host_model (
    output logic spi_sck, // Link clock, still between frames
    output logic spi_cs_n, // Chip select, active low
    output logic spi_si, // Serial data to device
    input wire logic spi_so, // Serial data from device
    input wire logic spi_so_oe_n // Device drive enable
);
    localparam int HALF = 32; // Half of the 64 ns link period
    logic [7:0] reply; // Last reply byte
    event reply_done; // Reply byte complete
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
        reply = 8'h00;
    end
    // ----------------------------------------
    // Frame driver, mode 0
    // ----------------------------------------
    task automatic frame(input logic [7:0] op, input logic [23:0] addr, input bit with_addr);
        logic [31:0] word;
        int n;
        word = {op, addr};
        n = with_addr ? 32 : 8;
        #7 spi_cs_n = 1'b0;
        // Opcode then address, MSB first
        for (int i = 0; i < n + (with_addr ? 8 : 0); i++) begin
            spi_si = (i < n) ? word[31-i] : ~spi_si;
            #HALF spi_sck = 1'b1;
            if (i >= n) begin
                reply[7-(i-n)] = spi_so_oe_n ? 1'b1 : spi_so; // Pulled up when released
            end
            #HALF spi_sck = 1'b0;
        end
        if (with_addr) begin
            -> reply_done;
        end
        #HALF spi_cs_n = 1'b1;
        // Released line never keeps its stale level
        spi_si = ~spi_si;
    endtask
endmodule

// ---- verification/test_flash_powerdown_reset_lockquery.sv ----
// Self-checking bench for the flash power-down and lock-query block
`timescale 1ns/1ns
`include "flash_pd_defs.svh"
module test_flash_powerdown_reset_lockquery;
    localparam int DEEP = 20; // Shortened long recovery
    logic clk_sys, sys_rst, jedec_reset, hw_reset_n, op_busy; // Design inputs
    logic [7:0] fourth_status_reg, third_status_reg; // Status inputs
    logic [`LOCK_BITS-1:0] lock_bits; // Lock store
    logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n; // Link wires
    logic op_abort, dev_reset, buffer_lost, cmd_ready, sleep_shallow, sleep_deep; // Outputs
    logic [1:0] op_class; // Last operation class
    logic [7:0] exp_q[$]; // Expected replies, oldest first
    logic [95:0] rnd; // Random lock pattern
    logic [23:0] addr; // Query address
    logic [23:0] edges[4] = '{24'h00f000, 24'h010000, 24'h3ef000, 24'h3f3000}; // Region edges
    logic [7:0] ops[15] = '{`OP_PROG_PAGE, `OP_PROG_SEQ_A, `OP_PROG_SEQ_B, `OP_PROG_DUAL, `OP_PROG_QUAD,
        `OP_PROG_RMW, `OP_PROG_NOERASE, `OP_PROG_SECURITY, `OP_ERASE_PAGE_A, `OP_ERASE_PAGE_B, `OP_ERASE_4K,
        `OP_ERASE_32K, `OP_ERASE_64K, `OP_ERASE_CHIP_A, `OP_ERASE_CHIP_B}; // Eight program, then erase
    int err_total, samples_checked, n_abort, n_reset, cnt, a0, r0;
    flash_pd_ctrl #(.DEEP_WAKE_CYCLES(DEEP)) DUT (.clk_sys, .sys_rst, .spi_sck, .spi_cs_n, .spi_si, .spi_so,
        .spi_so_oe_n, .jedec_reset, .hw_reset_n, .fourth_status_reg, .third_status_reg, .lock_bits, .op_busy,
        .op_abort, .dev_reset, .buffer_lost, .cmd_ready, .sleep_shallow, .sleep_deep, .op_class);
    flash_host_model host (.spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe_n);
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;
    // Pulse counters, sampled mid-cycle so each one-cycle pulse counts once
    always @(negedge clk_sys) begin
        if (op_abort === 1'b1) n_abort++;
        if (dev_reset === 1'b1) n_reset++;
    end
    // ----------------------------------------
    // Compare and helper tasks
    // ----------------------------------------
    task automatic cmp_val(string name, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", name, e, g);
            err_total++;
        end
    endtask
    task automatic cmp_bit(string name, logic e, logic g);
        cmp_val(name, {31'h0, e}, {31'h0, g});
    endtask
    task automatic step(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic send(logic [7:0] op);
        host.frame(op, 24'h0, 1'b0);
        step(8);
    endtask
    task automatic query(logic [7:0] op, logic [23:0] a, logic [7:0] e);
        exp_q.push_back(e);
        host.frame(op, a, 1'b1);
        step(8);
    endtask
    // Counts cycles until commands are accepted again, bounded
    task automatic wait_ready(output int n);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 5000) cmp_bit("cmd_ready wait", 1'b1, cmd_ready);
    endtask
    task automatic pulse(bit pin);
        @(posedge clk_sys);
        if (pin) hw_reset_n <= 1'b0;
        else jedec_reset <= 1'b1;
        step(4);
        @(posedge clk_sys);
        hw_reset_n <= 1'b1;
        jedec_reset <= 1'b0;
        step(8);
    endtask
    // Lock bit of the block holding an address
    function automatic logic [7:0] lock_exp(logic [23:0] a);
        int idx;
        idx = (a[21:16] == 6'h00) ? a[15:12] : (a[21:16] == 6'h3f) ? 78 + a[15:12] : 15 + a[21:16];
        return lock_bits[idx] ? `LOCK_LOCKED : `LOCK_UNLOCKED;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reply monitor pairs each reply with the oldest note
    always @(host.reply_done) begin
        if (exp_q.size() == 0) cmp_val("unexpected reply", 32'h0, 32'h1);
        else cmp_val("lock reply", 32'(exp_q.pop_front()), 32'(host.reply));
    end
    // Watchdog, far beyond the expected run
    initial begin
        #1000000;
        err_total++;
        summarize();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(70990));
        {sys_rst, jedec_reset, hw_reset_n, op_busy} = 4'b1010;
        fourth_status_reg = 8'h00;
        third_status_reg = 8'h00;
        lock_bits = '0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rnd = {$urandom, $urandom, $urandom};
        lock_bits <= rnd[`LOCK_BITS-1:0];
        step(4);
        cmp_bit("cmd_ready", 1'b1, cmd_ready);
        cmp_bit("sleep_deep", 1'b0, sleep_deep);
        cmp_bit("buffer_lost", 1'b1, buffer_lost);
        for (int i = 0; i < 12; i++) begin
            addr = (i < 4) ? edges[i] : {2'b00, 22'($urandom)};
            query(i[0] ? `OP_LOCK_QUERY_B : `OP_LOCK_QUERY_A, addr, lock_exp(addr));
        end
        $display("test reset and lock query finished");
        @(posedge clk_sys) fourth_status_reg <= 8'h80;
        r0 = n_reset;
        send(`OP_POWER_DOWN);
        cmp_bit("sleep_shallow", 1'b1, sleep_shallow);
        send(`OP_TERMINATE);
        query(`OP_LOCK_QUERY_A, 24'h0, 8'hff);
        cmp_bit("sleep_shallow", 1'b1, sleep_shallow);
        host.frame(`OP_RESUME, 24'h0, 1'b0);
        wait_ready(cnt);
        cmp_bit("short recovery", 1'b1, cnt >= `SHALLOW_WAKE_CYC - 2);
        send(`OP_POWER_DOWN);
        send(`OP_RESET_ENABLE);
        host.frame(`OP_RESET_DEVICE, 24'h0, 1'b0);
        wait_ready(cnt);
        cmp_bit("sleep_shallow", 1'b0, sleep_shallow);
        cmp_val("reset pulses", r0, n_reset);
        $display("test shallow sleep finished");
        @(posedge clk_sys) fourth_status_reg <= 8'h00;
        send(`OP_POWER_DOWN);
        cmp_bit("sleep_deep", 1'b1, sleep_deep);
        send(`OP_RESET_ENABLE);
        send(`OP_RESET_DEVICE);
        send(`OP_TERMINATE);
        cmp_bit("sleep_deep", 1'b1, sleep_deep);
        r0 = n_reset;
        host.frame(`OP_RESUME, 24'h0, 1'b0);
        wait_ready(cnt);
        cmp_bit("long recovery", 1'b1, cnt >= DEEP);
        cmp_val("reset pulses", r0 + 1, n_reset);
        @(posedge clk_sys) {fourth_status_reg, third_status_reg} <= 16'h8080;
        send(`OP_DEEP_DOWN);
        cmp_bit("sleep_deep", 1'b1, sleep_deep);
        pulse(1'b1);
        wait_ready(cnt);
        cmp_bit("sleep_deep", 1'b0, sleep_deep);
        @(posedge clk_sys) third_status_reg <= 8'h00;
        send(`OP_DEEP_DOWN);
        @(posedge clk_sys) third_status_reg <= 8'h80;
        pulse(1'b1);
        cmp_bit("sleep_deep", 1'b1, sleep_deep);
        pulse(1'b0);
        wait_ready(cnt);
        cmp_bit("sleep_deep", 1'b0, sleep_deep);
        // Power-on reset in mid-run wakes the deepest sleep at once
        send(`OP_DEEP_DOWN);
        @(posedge clk_sys) sys_rst <= 1'b1;
        step(2);
        @(posedge clk_sys) sys_rst <= 1'b0;
        step(2);
        cmp_bit("sleep_deep", 1'b0, sleep_deep);
        cmp_bit("cmd_ready", 1'b1, cmd_ready);
        $display("test deep sleep finished");
        for (int i = 0; i < 15; i++) begin
            send(ops[i]);
            cmp_val("op_class", (i < 8) ? 32'(flash_pd_pkg::CLASS_PROGRAM) : 32'(flash_pd_pkg::CLASS_ERASE),
                32'(op_class));
        end
        @(posedge clk_sys) op_busy <= 1'b1;
        a0 = n_abort;
        r0 = n_reset;
        send(`OP_TERMINATE);
        cmp_val("abort pulses", a0 + 1, n_abort);
        cmp_val("reset pulses", r0, n_reset);
        send(`OP_RESET_ENABLE);
        send(`OP_RESET_DEVICE);
        wait_ready(cnt);
        cmp_val("abort pulses", a0 + 2, n_abort);
        cmp_val("reset pulses", r0 + 1, n_reset);
        pulse(1'b1);
        wait_ready(cnt);
        cmp_val("reset pulses", r0 + 2, n_reset);
        @(posedge clk_sys) op_busy <= 1'b0;
        $display("test operation classes and aborts finished");
        summarize();
    end
endmodule
